// *** core/dbr_pkg.sv ***
package dbr_pkg;

   // ****************************************************************
   // Serial command codes
   // ****************************************************************
   localparam logic [7:0] CMD_STATUS_READ   = 8'hE4;
   localparam logic [7:0] CMD_CONTROL_WRITE = 8'hC4;
   localparam logic [7:0] CMD_MATCH_READ    = 8'hE2;
   localparam logic [7:0] CMD_MATCH_WRITE   = 8'hC2;

   // ****************************************************************
   // Status/control field positions
   // ****************************************************************
   localparam int BIT_PERMIT_HALT   = 7;
   localparam int BIT_HALT_ACTIVE   = 6;
   localparam int BIT_MATCH_ENABLE  = 5;
   localparam int BIT_FORCE_TAG     = 4;
   localparam int BIT_CLOCK_SELECT  = 3;
   localparam int BIT_LOW_POWER     = 2;
   localparam int BIT_LP_FAILURE    = 1;
   localparam int BIT_SLOW_FAILURE  = 0;

   localparam int STATUS_WIDTH = 8;
   localparam int ADDR_WIDTH   = 16;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic        RST_PERMIT_HALT  = 1'b0;
   localparam logic        RST_MATCH_ENABLE = 1'b0;
   localparam logic        RST_FORCE_TAG    = 1'b0;
   localparam logic        RST_CLOCK_SELECT = 1'b0;
   localparam logic [15:0] RST_MATCH_ADDR   = 16'h0000;

   typedef enum logic [2:0] {
      DBR_RUN    = 3'b001,
      DBR_LOWPWR = 3'b010,
      DBR_HALT   = 3'b100
   } dbr_state_t;

endpackage

// *** core/dbr_match.sv ***
`timescale 1ns/100ps
`default_nettype none
module dbr_match
   import dbr_pkg::*;
#(
   parameter int AW = dbr_pkg::ADDR_WIDTH
) (
   // Compare inputs
   input  wire logic [AW-1:0] i_cpu_addr,
   input  wire logic [AW-1:0] i_match_addr,
   input  wire logic          i_enable,
   input  wire logic          i_force_sel,
   // Requests
   output logic               o_force_hit,
   output logic               o_tag_hit
);
   logic hit;

   // Disabled compare yields nothing regardless of address or select
   assign hit         = i_enable && (i_cpu_addr == i_match_addr);
   assign o_force_hit = hit && i_force_sel;
   assign o_tag_hit   = hit && !i_force_sel;
endmodule
`default_nettype wire

// *** core/dbr_mode.sv ***
`timescale 1ns/100ps
`default_nettype none
module dbr_mode
   import dbr_pkg::*;
(
   // Clock and reset
   input  wire logic i_core_clk,
   input  wire logic i_rst_n,
   // Events
   input  wire logic i_halt_request,
   input  wire logic i_resume,
   input  wire logic i_cpu_low_power,
   // State
   output logic      o_halt_active,
   output logic      o_low_power_flag
);
   import dbr_pkg::*;

   dbr_state_t state;
   dbr_state_t next_state;
   logic       from_low_power;

   always_comb begin
      next_state = state;
      unique case (state)
         DBR_RUN: begin
            if (i_halt_request) begin
               next_state = DBR_HALT;
            end else if (i_cpu_low_power) begin
               next_state = DBR_LOWPWR;
            end
         end
         DBR_LOWPWR: begin
            // Halt command still pulls the CPU out of wait/stop
            if (i_halt_request) begin
               next_state = DBR_HALT;
            end else if (!i_cpu_low_power) begin
               next_state = DBR_RUN;
            end
         end
         DBR_HALT: begin
            if (i_resume) begin
               next_state = DBR_RUN;
            end
         end
         default: next_state = DBR_RUN;
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         state <= DBR_RUN;
      end else begin
         state <= next_state;
      end
   end

   // Remember halt was entered out of wait/stop
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         from_low_power <= 1'b0;
      end else if (state == DBR_LOWPWR && next_state == DBR_HALT) begin
         from_low_power <= 1'b1;
      end else if (next_state != DBR_HALT) begin
         from_low_power <= 1'b0;
      end
   end

   assign o_halt_active    = (state == DBR_HALT);
   assign o_low_power_flag = (state == DBR_LOWPWR) ||
                             (state == DBR_HALT && from_low_power);
endmodule
`default_nettype wire

// *** core/dbr_regs.sv ***
// Overview of operation
// - Registers reachable only by serial commands
// - Eight-bit status read, control write
// - Permit-halt write ignored while halted
// - Status bits are read-only
// - Clock select writable at any time
// - Permit-halt sticky until normal reset
// - Halt-active reads one while halted
// - Breakpoint disabled when enable clear
// - Force select halts at instruction boundary
// - Tag select halts when tagged opcode executes
// - Clock select resets to alternate clock
// - Low-power flag in wait/stop or halt-from-it
// - Halt command exits wait/stop
// - Set failure flag on low-power collision
// - Slow-access failure always zero
// - Sixteen-bit match address, own commands
// - Codes E4 status read, C4 control write
// - Codes E2 match read, C2 match write
// - Breakpoint enable resets to zero
`timescale 1ns/100ps
`default_nettype none
module dbr_regs
   import dbr_pkg::*;
#(
   parameter int AW = dbr_pkg::ADDR_WIDTH
) (
   // Clock and reset
   input  wire logic                           i_core_clk,
   input  wire logic                           i_rst_n,
   // Decoded serial command
   input  wire logic                           i_cmd_valid,
   input  wire logic [7:0]                     i_cmd_code,
   input  wire logic [dbr_pkg::STATUS_WIDTH-1:0] i_cmd_byte,
   input  wire logic [AW-1:0]                  i_cmd_word,
   // Command read data
   output logic [dbr_pkg::STATUS_WIDTH-1:0]    o_status_data,
   output logic [AW-1:0]                       o_match_data,
   output logic                                o_rd_valid,
   // Halt command and resume from the command decoder
   input  wire logic                           i_halt_cmd,
   input  wire logic                           i_resume,
   // CPU side
   input  wire logic [AW-1:0]                  i_cpu_addr,
   input  wire logic                           i_cpu_low_power,
   input  wire logic                           i_mem_access_fail,
   input  wire logic                           i_opcode_fetch,
   input  wire logic                           i_instr_boundary,
   input  wire logic                           i_tagged_at_queue_end,
   output logic                                o_halt_request,
   output logic                                o_opcode_tag,
   output logic                                o_link_clock_select,
   output logic                                o_halt_active
);
   import dbr_pkg::*;

   // ****************************************************************
   // Control and status storage
   // ****************************************************************
   logic          permit_halt_mode;
   logic          match_breakpoint_enable;
   logic          force_or_tag_select;
   logic          link_clock_select;
   logic          low_power_access_failure;
   logic [AW-1:0] breakpoint_match_address;
   logic          force_pending;
   logic          halt_active;
   logic          low_power_state_flag;
   logic          force_hit;
   logic          tag_hit;
   logic          halt_req;
   logic [STATUS_WIDTH-1:0] debug_status_control;

   function automatic logic is_cmd(input logic [7:0] code, input logic [7:0] want);
      is_cmd = (code == want);
   endfunction

   // Only these serial commands reach the registers; no memory path exists
   logic wr_ctrl;
   logic wr_match;
   logic rd_any;
   assign wr_ctrl  = i_cmd_valid && is_cmd(i_cmd_code, CMD_CONTROL_WRITE);
   assign wr_match = i_cmd_valid && is_cmd(i_cmd_code, CMD_MATCH_WRITE);
   assign rd_any   = i_cmd_valid && (is_cmd(i_cmd_code, CMD_STATUS_READ) ||
                                     is_cmd(i_cmd_code, CMD_MATCH_READ));

   // ****************************************************************
   // Writable control bits
   // ****************************************************************
   // Changing permit while halted would forbid the mode already in force
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         permit_halt_mode <= RST_PERMIT_HALT;
      end else if (wr_ctrl && !halt_active && i_cmd_byte[BIT_PERMIT_HALT]) begin
         permit_halt_mode <= 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         match_breakpoint_enable <= RST_MATCH_ENABLE;
         force_or_tag_select     <= RST_FORCE_TAG;
         link_clock_select       <= RST_CLOCK_SELECT;
      end else if (wr_ctrl) begin
         match_breakpoint_enable <= i_cmd_byte[BIT_MATCH_ENABLE];
         force_or_tag_select     <= i_cmd_byte[BIT_FORCE_TAG];
         link_clock_select       <= i_cmd_byte[BIT_CLOCK_SELECT];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         breakpoint_match_address <= RST_MATCH_ADDR;
      end else if (wr_match) begin
         breakpoint_match_address <= i_cmd_word;
      end
   end

   // ****************************************************************
   // Status flags
   // ****************************************************************
   // Failure sets; cleared by a resume command, not by leaving wait/stop
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         low_power_access_failure <= 1'b0;
      end else if (i_mem_access_fail) begin
         low_power_access_failure <= 1'b1;
      end else if (i_resume) begin
         low_power_access_failure <= 1'b0;
      end
   end

   // ****************************************************************
   // Breakpoint
   // ****************************************************************
   dbr_match #(
      .AW (AW)
   ) u_match (
      .i_cpu_addr   (i_cpu_addr),
      .i_match_addr (breakpoint_match_address),
      .i_enable     (match_breakpoint_enable),
      .i_force_sel  (force_or_tag_select),
      .o_force_hit  (force_hit),
      .o_tag_hit    (tag_hit)
   );

   // Forced hit waits for the next instruction boundary
   // Dropped when disabled or halted, so no stale hit fires later
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         force_pending <= 1'b0;
      end else if (halt_req || halt_active || !match_breakpoint_enable) begin
         force_pending <= 1'b0;
      end else if (force_hit) begin
         force_pending <= 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_opcode_tag <= 1'b0;
      end else begin
         o_opcode_tag <= tag_hit && i_opcode_fetch;
      end
   end

   // Halt only when permitted; entry reasons all funnel here
   assign halt_req = permit_halt_mode && !halt_active &&
                     (i_halt_cmd ||
                      ((force_pending || force_hit) && i_instr_boundary) ||
                      i_tagged_at_queue_end);

   dbr_mode u_mode (
      .i_core_clk       (i_core_clk),
      .i_rst_n          (i_rst_n),
      .i_halt_request   (halt_req),
      .i_resume         (i_resume),
      .i_cpu_low_power  (i_cpu_low_power),
      .o_halt_active    (halt_active),
      .o_low_power_flag (low_power_state_flag)
   );

   // ****************************************************************
   // Read-back
   // ****************************************************************
   always_comb begin
      debug_status_control                   = '0;
      debug_status_control[BIT_PERMIT_HALT]  = permit_halt_mode;
      debug_status_control[BIT_HALT_ACTIVE]  = halt_active;
      debug_status_control[BIT_MATCH_ENABLE] = match_breakpoint_enable;
      debug_status_control[BIT_FORCE_TAG]    = force_or_tag_select;
      debug_status_control[BIT_CLOCK_SELECT] = link_clock_select;
      debug_status_control[BIT_LOW_POWER]    = low_power_state_flag;
      debug_status_control[BIT_LP_FAILURE]   = low_power_access_failure;
      debug_status_control[BIT_SLOW_FAILURE] = 1'b0;
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         o_status_data <= '0;
         o_match_data  <= '0;
         o_rd_valid    <= 1'b0;
      end else begin
         o_rd_valid <= rd_any;
         if (i_cmd_valid && is_cmd(i_cmd_code, CMD_STATUS_READ)) begin
            o_status_data <= debug_status_control;
         end
         if (i_cmd_valid && is_cmd(i_cmd_code, CMD_MATCH_READ)) begin
            o_match_data <= breakpoint_match_address;
         end
      end
   end

   assign o_halt_request      = halt_req;
   assign o_link_clock_select = link_clock_select;
   assign o_halt_active       = halt_active;
endmodule
`default_nettype wire

// *** verification/dbr_regs_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module dbr_regs_monitor
   import dbr_pkg::*;
#(
   parameter int AW = dbr_pkg::ADDR_WIDTH
) (
   // Watched ports
   input wire logic          i_core_clk,
   input wire logic          i_rst_n,
   input wire logic          i_cmd_valid,
   input wire logic [7:0]    i_cmd_code,
   input wire logic [7:0]    i_cmd_byte,
   input wire logic [AW-1:0] i_cmd_word,
   input wire logic [7:0]    o_status_data,
   input wire logic [AW-1:0] o_match_data,
   input wire logic          o_rd_valid,
   input wire logic          i_halt_cmd,
   input wire logic          i_resume,
   input wire logic [AW-1:0] i_cpu_addr,
   input wire logic          i_cpu_low_power,
   input wire logic          i_mem_access_fail,
   input wire logic          i_opcode_fetch,
   input wire logic          i_instr_boundary,
   input wire logic          i_tagged_at_queue_end,
   input wire logic          o_halt_request,
   input wire logic          o_opcode_tag,
   input wire logic          o_link_clock_select,
   input wire logic          o_halt_active
);
   logic [3:0]    wr;
   logic [AW-1:0] bkpt;
   logic          st_rd;
   logic          hit;
   assign st_rd = i_cmd_valid && i_cmd_code == CMD_STATUS_READ;
   assign hit   = wr[2] && i_cpu_addr == bkpt;
   // Shadow of host state: permit, enable, force, clock; permit locked while halted
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_n) begin
         wr   <= 4'h0;
         bkpt <= '0;
      end else if (i_cmd_valid && i_cmd_code == CMD_CONTROL_WRITE) begin
         wr <= {wr[3] | (i_cmd_byte[7] & ~o_halt_active), i_cmd_byte[5:3]};
      end else if (i_cmd_valid && i_cmd_code == CMD_MATCH_WRITE) begin
         bkpt <= i_cmd_word;
      end
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   property p_status; st_rd |=> {o_status_data[7], o_status_data[5:3]} == $past(wr); endproperty
   a_status: assert property (p_status) else $error("control bits wrong");
   property p_active;
      st_rd |=> o_status_data[6] == $past(o_halt_active) && !o_status_data[0]; endproperty
   a_active: assert property (p_active) else $error("status flags wrong");
   property p_match;
      i_cmd_valid && i_cmd_code == CMD_MATCH_READ |=> o_match_data == $past(bkpt); endproperty
   a_match: assert property (p_match) else $error("match readback wrong");
   property p_tagsel; o_opcode_tag |-> $past(wr[2:1]) == 2'h2; endproperty
   a_tagsel: assert property (p_tagsel) else $error("tag while not in tag mode");
   property p_force;
      hit && wr[1] && wr[3] && i_instr_boundary && !o_halt_active
         |-> o_halt_request ##1 o_halt_active; endproperty
   a_force: assert property (p_force) else $error("forced hit missed");
   property p_tag; hit && !wr[1] && i_opcode_fetch && !o_halt_active |=> o_opcode_tag; endproperty
   a_tag: assert property (p_tag) else $error("opcode not tagged");
   property p_halt; i_halt_cmd && wr[3] && !o_halt_active |=> o_halt_active; endproperty
   a_halt: assert property (p_halt) else $error("halt command lost");
   property p_lp;
      $past(i_rst_n) && $past(i_cpu_low_power) && i_cpu_low_power && st_rd
         |=> o_status_data[2]; endproperty
   a_lp: assert property (p_lp) else $error("low power flag clear");
endmodule
bind dbr_regs dbr_regs_monitor #(.AW(AW)) u_dbr_mon (
   .i_core_clk, .i_rst_n, .i_cmd_valid, .i_cmd_code, .i_cmd_byte, .i_cmd_word,
   .o_status_data, .o_match_data, .o_rd_valid, .i_halt_cmd, .i_resume, .i_cpu_addr,
   .i_cpu_low_power, .i_mem_access_fail, .i_opcode_fetch, .i_instr_boundary,
   .i_tagged_at_queue_end, .o_halt_request, .o_opcode_tag, .o_link_clock_select,
   .o_halt_active
);
`default_nettype wire

// *** verification/dbr_host.sv ***
`timescale 1ns/100ps
`default_nettype none
module dbr_host
   import dbr_pkg::*;
(
   // Serial command side
   input  wire logic        i_core_clk,
   output logic             o_cmd_valid,
   output logic [7:0]       o_cmd_code,
   output logic [7:0]       o_cmd_byte,
   output logic [15:0]      o_cmd_word,
   output logic             o_halt_cmd,
   output logic             o_resume,
   input  wire logic        i_rd_valid,
   input  wire logic [7:0]  i_status_data,
   input  wire logic [15:0] i_match_data
);
   initial begin
      {o_cmd_valid, o_cmd_code, o_cmd_byte, o_cmd_word, o_halt_cmd, o_resume} = '0;
   end
   // Idle lines carry the inverse, so stale data never looks current
   task automatic send(input logic [7:0] c, input logic [7:0] b, input logic [15:0] w);
      @(posedge i_core_clk);
      o_cmd_valid <= 1'b1;
      o_cmd_code  <= c;
      o_cmd_byte  <= b;
      o_cmd_word  <= w;
      @(posedge i_core_clk);
      o_cmd_valid <= 1'b0;
      o_cmd_code  <= ~c;
      o_cmd_byte  <= ~b;
      o_cmd_word  <= ~w;
      #1;
   endtask
   task automatic read(input logic [7:0] c, output logic v, output logic [15:0] d);
      send(c, 8'h00, 16'h0000);
      v = i_rd_valid;
      d = (c == CMD_STATUS_READ) ? {8'h00, i_status_data} : i_match_data;
   endtask
   // Halt when h is set, resume otherwise
   task automatic ctl(input logic h);
      @(posedge i_core_clk);
      o_halt_cmd <= h;
      o_resume   <= ~h;
      @(posedge i_core_clk);
      o_halt_cmd <= 1'b0;
      o_resume   <= 1'b0;
      #1;
   endtask
endmodule
`default_nettype wire

// *** verification/dbr_regs_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin miscompares++; \
   $display("[FAIL] %s expected %h seen %h", n, e, s); end end
module dbr_regs_tb;
   import dbr_pkg::*;
   logic        i_core_clk, i_rst_n, i_cmd_valid, i_halt_cmd, i_resume, o_rd_valid, rv;
   logic        i_cpu_low_power, i_mem_access_fail, i_opcode_fetch, i_instr_boundary;
   logic        i_tagged_at_queue_end, o_halt_request, o_opcode_tag;
   logic        o_link_clock_select, o_halt_active;
   logic [7:0]  i_cmd_code, i_cmd_byte, o_status_data;
   logic [15:0] i_cmd_word, o_match_data, i_cpu_addr, rd;
   int          miscompares, samples_checked;
   dbr_host host (.i_core_clk, .o_cmd_valid(i_cmd_valid), .o_cmd_code(i_cmd_code),
      .o_cmd_byte(i_cmd_byte), .o_cmd_word(i_cmd_word), .o_halt_cmd(i_halt_cmd),
      .o_resume(i_resume), .i_rd_valid(o_rd_valid), .i_status_data(o_status_data),
      .i_match_data(o_match_data));
   dbr_regs #(.AW(16)) dut (.i_core_clk, .i_rst_n, .i_cmd_valid, .i_cmd_code,
      .i_cmd_byte, .i_cmd_word, .o_status_data, .o_match_data, .o_rd_valid, .i_halt_cmd,
      .i_resume, .i_cpu_addr, .i_cpu_low_power, .i_mem_access_fail, .i_opcode_fetch,
      .i_instr_boundary, .i_tagged_at_queue_end, .o_halt_request, .o_opcode_tag,
      .o_link_clock_select, .o_halt_active);
   initial begin
      i_core_clk = 1'b0;
      forever #2 i_core_clk = ~i_core_clk;
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task automatic do_reset();
      @(posedge i_core_clk);
      i_rst_n <= 1'b0;
      repeat (8) @(posedge i_core_clk);
      i_rst_n <= 1'b1;
   endtask
   task automatic rd_chk(input string n, input logic [7:0] c, input logic [15:0] e);
      host.read(c, rv, rd);
      `CHK(n, 1'b1, rv)
      `CHK(n, e, rd)
   endtask
   task automatic cpu(input logic [15:0] a, input logic f, input logic b, input logic q);
      @(posedge i_core_clk);
      {i_opcode_fetch, i_instr_boundary, i_tagged_at_queue_end} <= {f, b, q};
      i_cpu_addr <= a;
      @(posedge i_core_clk);
      {i_opcode_fetch, i_instr_boundary, i_tagged_at_queue_end} <= 3'h0;
      i_cpu_addr <= ~a;
      #1;
   endtask
   initial begin
      repeat (3000) @(posedge i_core_clk);
      miscompares++;
      report_and_stop();
   end
   initial begin
      {i_rst_n, i_cpu_low_power, i_mem_access_fail, i_cpu_addr} = '0;
      {i_opcode_fetch, i_instr_boundary, i_tagged_at_queue_end} = 3'h0;
      do_reset();
      rd_chk("status", CMD_STATUS_READ, 16'h0000);
      rd_chk("match", CMD_MATCH_READ, 16'h0000);
      host.ctl(1'b1);
      `CHK("halted", 1'b0, o_halt_active)
      host.send(CMD_CONTROL_WRITE, 8'hFF, 16'h0000);
      rd_chk("status", CMD_STATUS_READ, 16'h00B8);
      `CHK("clksel", 1'b1, o_link_clock_select)
      host.ctl(1'b1);
      rd_chk("status", CMD_STATUS_READ, 16'h00F8);
      host.send(CMD_CONTROL_WRITE, 8'h00, 16'h0000);
      rd_chk("status", CMD_STATUS_READ, 16'h00C0);
      host.send(CMD_MATCH_WRITE, 8'h00, 16'h1234);
      rd_chk("match", CMD_MATCH_READ, 16'h1234);
      host.send(CMD_CONTROL_WRITE, 8'hB0, 16'h0000);
      host.ctl(1'b0);
      `CHK("halted", 1'b0, o_halt_active)
      $display("test control finished");
      cpu(16'h1234, 1'b0, 1'b1, 1'b0);
      `CHK("halted", 1'b1, o_halt_active)
      host.ctl(1'b0);
      host.send(CMD_CONTROL_WRITE, 8'hA0, 16'h0000);
      cpu(16'h1234, 1'b1, 1'b0, 1'b0);
      `CHK("tag", 1'b1, o_opcode_tag)
      `CHK("halted", 1'b0, o_halt_active)
      cpu(16'h0000, 1'b0, 1'b0, 1'b1);
      `CHK("halted", 1'b1, o_halt_active)
      host.ctl(1'b0);
      host.send(CMD_CONTROL_WRITE, 8'hB0, 16'h0000);
      cpu(16'h1234, 1'b0, 1'b0, 1'b0);
      `CHK("halted", 1'b0, o_halt_active)
      host.send(CMD_CONTROL_WRITE, 8'h90, 16'h0000);
      cpu(16'h1234, 1'b1, 1'b1, 1'b0);
      `CHK("halted", 1'b0, o_halt_active)
      `CHK("tag", 1'b0, o_opcode_tag)
      $display("test breakpoint finished");
      @(posedge i_core_clk);
      i_cpu_low_power <= 1'b1;
      rd_chk("status", CMD_STATUS_READ, 16'h0094);
      @(posedge i_core_clk);
      i_mem_access_fail <= 1'b1;
      @(posedge i_core_clk);
      i_mem_access_fail <= 1'b0;
      rd_chk("status", CMD_STATUS_READ, 16'h0096);
      host.ctl(1'b1);
      `CHK("halted", 1'b1, o_halt_active)
      rd_chk("match", CMD_MATCH_READ, 16'h1234);
      @(posedge i_core_clk);
      i_cpu_low_power <= 1'b0;
      rd_chk("status", CMD_STATUS_READ, 16'h00D6);
      host.ctl(1'b0);
      rd_chk("status", CMD_STATUS_READ, 16'h0090);
      $display("test low power finished");
      do_reset();
      rd_chk("status", CMD_STATUS_READ, 16'h0000);
      `CHK("clksel", 1'b0, o_link_clock_select)
      $display("test second reset finished");
      report_and_stop();
   end
endmodule
`default_nettype wire
